// ### hw/opcode_decode_map.vh
// Constants for the first-byte decoder and execution-state accounting
`ifndef OPCODE_DECODE_MAP_VH
`define OPCODE_DECODE_MAP_VH

// Operation classes reported on opClass
`define CLS_OTHER        4'h0
`define CLS_NOP          4'h1
`define CLS_SLEEP        4'h2
`define CLS_BRANCH       4'h3
`define CLS_CALL         4'h4
`define CLS_XFER_REG     4'h5
`define CLS_XFER_IND     4'h6
`define CLS_XFER_STACK   4'h7
`define CLS_XFER_DISP    4'h8
`define CLS_XFER_ABS     4'h9
`define CLS_XFER_IMM     4'ha
`define CLS_BIT_REG      4'hb
`define CLS_BIT_MEM      4'hc
`define CLS_BIT_SHARED   4'hd

// First-byte codes and code groups
`define OPC_NOP          8'h00
`define OPC_SLEEP        8'h01
`define OPC_XFER_REG_B   8'h0c
`define OPC_XFER_REG_W   8'h0d
`define OPC_BRANCH_HI    4'h4
`define OPC_CALL_REG     8'h5d
`define OPC_CALL_ABS     8'h5e
`define OPC_CALL_IND     8'h5f
`define OPC_BIT_SET_REG  8'h70
`define OPC_BIT_MEM_REGA 8'h7d
`define OPC_BIT_MEM_ABS  8'h7f
`define OPC_LOAD_ABS8_HI 4'h2
`define OPC_STOR_ABS8_HI 4'h3
`define OPC_XFER_IMM_HI  4'hf
`define OPC_XFER_GRP_HI  4'h6
`define OPC_SHARED_HI    4'h6
`define OPC_SHARED_LO    4'h7

// Cycle-type indices
`define CYC_FETCH        3'h0
`define CYC_BRANCH_RD    3'h1
`define CYC_STACK        3'h2
`define CYC_BYTE         3'h3
`define CYC_WORD         3'h4
`define CYC_INTERNAL     3'h5

// State costs per cycle
`define COST_MEM         2'h2
`define COST_INTERNAL    2'h1
`define COST_PERI_FAST   2'h2
`define COST_PERI_SLOW   2'h3
`define COST_PERI_WORD   2'h2

// Cycle counts used by the decoder
`define CNT_ZERO         2'h0
`define CNT_ONE          2'h1
`define CNT_TWO          2'h2

`endif

// ### hw/state_cost_table.v
// State cost of one cycle type by access location
`timescale 1ns/10ps
`default_nettype none
`include "opcode_decode_map.vh"

module state_cost_table
(
    input  wire [2:0] cycleType,
    input  wire       toPeripheral,
    input  wire       slowPeripheral,
    output reg  [1:0] stateCost
);

    // Memory cycles cost 2, internal 1; peripheral data access 2 or 3
    always @*
    begin
        case (cycleType)
            `CYC_FETCH:     stateCost = `COST_MEM;
            `CYC_BRANCH_RD: stateCost = `COST_MEM;
            `CYC_STACK:     stateCost = `COST_MEM;
            `CYC_BYTE:      stateCost = toPeripheral ?
                                (slowPeripheral ? `COST_PERI_SLOW : `COST_PERI_FAST) : `COST_MEM;
            `CYC_WORD:      stateCost = toPeripheral ? `COST_PERI_WORD : `COST_MEM;
            `CYC_INTERNAL:  stateCost = `COST_INTERNAL;
            default:        stateCost = `COST_MEM;
        endcase
    end

endmodule
`default_nettype wire

// ### hw/opcode_decode_state_timing.v
// First-byte opcode decoder with per-instruction execution-state accounting
//
// Function
// - The operation class comes from bits 15 to 8 of the first instruction word.
// - Where one first-byte code serves two groups, bit 7 of the first word picks the group, 0 one and 1 the other.
// - Push and pop have no codes of their own and decode as the matching data-transfer encodings.
// - Total states are the sum over six cycle types of cycle count times state cost.
// - The state cost of a cycle depends on whether it goes to on-chip memory or a peripheral module.
// - An instruction fetch from on-chip memory costs 2 states.
// - A branch-address read and a stack operation to on-chip memory each cost 2 states.
// - A byte access to a peripheral module costs 2 or 3 states depending on the module.
// - Bit-set on a memory operand takes two fetches and two byte accesses, read then write-back.
`timescale 1ns/10ps
`default_nettype none
`include "opcode_decode_map.vh"

module opcode_decode_state_timing
(
    input  wire        clk_sys,
    input  wire        reset_n,
    input  wire [15:0] instrWord,
    input  wire        instrValid,
    input  wire        dataToPeripheral,
    input  wire        slowPeripheral,
    output reg         decodeReady,
    output reg  [3:0]  opClass,
    output reg         groupSelect,
    output reg         storeDirection,
    output reg  [11:0] cycleCounts,
    output reg  [7:0]  totalStates,
    output reg         resultValid
);

    // One-hot sequencer states
    localparam [2:0] ST_IDLE   = 3'b001;
    localparam [2:0] ST_WEIGHT = 3'b010;
    localparam [2:0] ST_DONE   = 3'b100;

    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg         heldPeripheral;
    reg         heldSlow;
    wire        takeReq;
    wire [7:0]  firstByte;
    wire        pickBit;
    wire [11:0] next_counts;
    wire [3:0]  next_class;
    wire [23:0] stateCosts;
    wire [7:0]  costSum;
    wire [7:0]  partial [0:6];

    // First byte picks the class, bit 7 of the word the group
    assign firstByte = instrWord[15:8];
    assign pickBit   = instrWord[7];

    // Class of the first byte
    function [3:0] classOf;
        input [7:0] fb;
        begin
            if (fb == `OPC_NOP)
                classOf = `CLS_NOP;
            else if (fb == `OPC_SLEEP)
                classOf = `CLS_SLEEP;
            else if (fb == `OPC_XFER_REG_B || fb == `OPC_XFER_REG_W)
                classOf = `CLS_XFER_REG;
            else if (fb[7:4] == `OPC_BRANCH_HI)
                classOf = `CLS_BRANCH;
            else if (fb == `OPC_CALL_REG || fb == `OPC_CALL_ABS || fb == `OPC_CALL_IND)
                classOf = `CLS_CALL;
            else if (fb == `OPC_BIT_SET_REG)
                classOf = `CLS_BIT_REG;
            else if (fb == `OPC_BIT_MEM_REGA || fb == `OPC_BIT_MEM_ABS)
                classOf = `CLS_BIT_MEM;
            else if (fb[7:4] == `OPC_LOAD_ABS8_HI || fb[7:4] == `OPC_STOR_ABS8_HI)
                classOf = `CLS_XFER_ABS;
            else if (fb[7:4] == `OPC_XFER_IMM_HI)
                classOf = `CLS_XFER_IMM;
            else if (fb[7:4] == `OPC_XFER_GRP_HI && fb[3])
            begin
                // Indirect, absolute, stack and displacement transfers
                case (fb[2:1])
                    2'h0:    classOf = `CLS_XFER_IND;
                    2'h1:    classOf = `CLS_XFER_ABS;
                    2'h2:    classOf = `CLS_XFER_STACK;
                    default: classOf = `CLS_XFER_DISP;
                endcase
            end
            else if (fb[7:4] == `OPC_SHARED_HI || fb[7:4] == `OPC_SHARED_LO)
                classOf = `CLS_BIT_SHARED;
            else
                classOf = `CLS_OTHER;
        end
    endfunction

    // Cycle counts packed {N,M,L,K,J,I}, two bits each
    function [11:0] countsOf;
        input [3:0] cls;
        input [7:0] fb;
        reg         isWord;
        begin
            isWord = fb[0];
            countsOf = {`CNT_ZERO, `CNT_ZERO, `CNT_ZERO, `CNT_ZERO, `CNT_ZERO, `CNT_ONE};
            // Default is a single fetch; each class below overrides it
            case (cls)
                `CLS_BRANCH:
                    countsOf = {`CNT_ZERO, `CNT_ZERO, `CNT_ZERO, `CNT_ZERO, `CNT_ZERO, `CNT_TWO};
                `CLS_CALL:
                begin
                    if (fb == `OPC_CALL_REG)
                        countsOf = {`CNT_ZERO, `CNT_ZERO, `CNT_ZERO, `CNT_ONE, `CNT_ZERO, `CNT_TWO};
                    else if (fb == `OPC_CALL_ABS)
                        countsOf = {`CNT_TWO, `CNT_ZERO, `CNT_ZERO, `CNT_ONE, `CNT_ZERO, `CNT_TWO};
                    else
                        countsOf = {`CNT_ZERO, `CNT_ZERO, `CNT_ZERO, `CNT_ONE, `CNT_ONE, `CNT_TWO};
                end
                `CLS_BIT_MEM:
                    countsOf = {`CNT_ZERO, `CNT_ZERO, `CNT_TWO, `CNT_ZERO, `CNT_ZERO, `CNT_TWO};
                `CLS_XFER_IND:
                    countsOf = isWord ? {`CNT_ZERO, `CNT_ONE, `CNT_ZERO, `CNT_ZERO, `CNT_ZERO, `CNT_ONE}
                                      : {`CNT_ZERO, `CNT_ZERO, `CNT_ONE, `CNT_ZERO, `CNT_ZERO, `CNT_ONE};
                `CLS_XFER_STACK:
                    // Push/pop share these post-increment/pre-decrement forms
                    countsOf = isWord ? {`CNT_TWO, `CNT_ONE, `CNT_ZERO, `CNT_ZERO, `CNT_ZERO, `CNT_ONE}
                                      : {`CNT_TWO, `CNT_ZERO, `CNT_ONE, `CNT_ZERO, `CNT_ZERO, `CNT_ONE};
                `CLS_XFER_DISP:
                    countsOf = isWord ? {`CNT_ZERO, `CNT_ONE, `CNT_ZERO, `CNT_ZERO, `CNT_ZERO, `CNT_TWO}
                                      : {`CNT_ZERO, `CNT_ZERO, `CNT_ONE, `CNT_ZERO, `CNT_ZERO, `CNT_TWO};
                `CLS_XFER_ABS:
                begin
                    if (fb[7:4] == `OPC_XFER_GRP_HI)
                        countsOf = isWord ? {`CNT_ZERO, `CNT_ONE, `CNT_ZERO, `CNT_ZERO, `CNT_ZERO, `CNT_TWO}
                                          : {`CNT_ZERO, `CNT_ZERO, `CNT_ONE, `CNT_ZERO, `CNT_ZERO, `CNT_TWO};
                    else
                        countsOf = {`CNT_ZERO, `CNT_ZERO, `CNT_ONE, `CNT_ZERO, `CNT_ZERO, `CNT_ONE};
                end
                default:
                    countsOf = {`CNT_ZERO, `CNT_ZERO, `CNT_ZERO, `CNT_ZERO, `CNT_ZERO, `CNT_ONE};
            endcase
        end
    endfunction

    assign next_class  = classOf(firstByte);
    assign next_counts = countsOf(next_class, firstByte);

    // Per-type state cost and weighted sum
    assign partial[0] = 8'h00;
    genvar t;
    generate
        for (t = 0; t < 6; t = t + 1)
        begin : g_weight
            // Cycle-type index of this stage, cut to the port width
            localparam integer TYPE_NUM = t;
            wire [3:0] weighted;
            state_cost_table u_cost
            (
                .cycleType      (TYPE_NUM[2:0]),
                .toPeripheral   (heldPeripheral),
                .slowPeripheral (heldSlow),
                .stateCost      (stateCosts[2*t+1:2*t])
            );
            // Widen both factors first so that a count of 3 at cost 3 (9) keeps all four bits
            assign weighted     = {2'b00, cycleCounts[2*t+1:2*t]} * {2'b00, stateCosts[2*t+1:2*t]};
            assign partial[t+1] = partial[t] + {4'h0, weighted};
        end
    endgenerate
    assign costSum = partial[6];

    // A strobe is taken only while idle; in other states it is ignored
    assign takeReq = (state == ST_IDLE) && instrValid;

    // Sequencer next state
    always @*
    begin
        case (state)
            ST_IDLE:   next_state = takeReq ? ST_WEIGHT : ST_IDLE;
            ST_WEIGHT: next_state = ST_DONE;
            ST_DONE:   next_state = ST_IDLE;
            default:   next_state = ST_IDLE;
        endcase
    end

    // Decode capture, weighting and result
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            // Idle and ready, no result pending
            state          <= ST_IDLE;
            decodeReady    <= 1'b1;
            opClass        <= `CLS_OTHER;
            groupSelect    <= 1'b0;
            storeDirection <= 1'b0;
            cycleCounts    <= 12'h000;
            totalStates    <= 8'h00;
            resultValid    <= 1'b0;
            heldPeripheral <= 1'b0;
            heldSlow       <= 1'b0;
        end
        else
        begin
            // Ready mirrors the idle state; the result flag pulses for one cycle
            state       <= next_state;
            decodeReady <= (next_state == ST_IDLE);
            resultValid <= (state == ST_WEIGHT);
            if (takeReq)
            begin
                opClass        <= next_class;
                groupSelect    <= (next_class == `CLS_BIT_SHARED) ? pickBit : 1'b0;
                storeDirection <= (firstByte[7:4] == `OPC_STOR_ABS8_HI) ||
                                  ((firstByte[7:4] == `OPC_XFER_GRP_HI) && firstByte[3] && pickBit);
                cycleCounts    <= next_counts;
                heldPeripheral <= dataToPeripheral;
                heldSlow       <= slowPeripheral;
            end
            // Total is taken once the held counts and location selects have settled
            if (state == ST_WEIGHT)
                totalStates <= costSum;
        end
    end

endmodule
`default_nettype wire

// ### verif/access_target_model.sv
// Far-side access target: on-chip memory or a peripheral module
`timescale 1ns/10ps
`default_nettype none
module access_target_model
(
    input  wire logic [1:0] targetSel,
    output logic            dataToPeripheral,
    output logic            slowPeripheral
);
    // Select 0 is memory; odd selects are slow peripheral modules
    assign dataToPeripheral = (targetSel != 2'h0);
    assign slowPeripheral   = targetSel[0] && dataToPeripheral;
endmodule
`default_nettype wire

// ### verif/opcode_decode_asserts.sv
// Assertions on handshake timing, cycle counts and state totals
`timescale 1ns/10ps
`default_nettype none
module opcode_decode_checker
(
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic [15:0] instrWord,
    input wire logic        instrValid,
    input wire logic        dataToPeripheral,
    input wire logic        slowPeripheral,
    input wire logic        decodeReady,
    input wire logic [3:0]  opClass,
    input wire logic        groupSelect,
    input wire logic        storeDirection,
    input wire logic [11:0] cycleCounts,
    input wire logic [7:0]  totalStates,
    input wire logic        resultValid
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // A request taken while idle
    wire take = decodeReady && instrValid;
    take_busy_a: assert property (take |=> !decodeReady [*2] ##1 decodeReady)
        else $error("Ready timing wrong");
    result_pulse_a: assert property (take |-> ##2 resultValid ##1 !resultValid)
        else $error("Result pulse wrong");
    branch_counts_a: assert property (take && instrWord[15:12] == 4'h4 |=> cycleCounts == 12'h002)
        else $error("Branch counts wrong");
    bitset_counts_a: assert property (take && instrWord[15:8] == 8'h7d |=> cycleCounts == 12'h082)
        else $error("Bit-set counts wrong");
    fetch_cost_a: assert property (take && instrWord[15:12] == 4'h4 |-> ##2 totalStates == 8'h04)
        else $error("Fetch cost wrong");
    call_cost_a: assert property (take && instrWord[15:8] == 8'h5f |-> ##2 totalStates == 8'h08)
        else $error("Indirect call total wrong");
    slow_byte_a: assert property (take && instrWord[15:12] == 4'h2 && slowPeripheral |-> ##2 totalStates == 8'h05)
        else $error("Slow byte total wrong");
    mem_byte_a: assert property (take && instrWord[15:12] == 4'h2 && !dataToPeripheral |-> ##2 totalStates == 8'h04)
        else $error("Memory byte total wrong");
    group_pick_a: assert property (take && instrWord[15:10] == 6'h1d |=> groupSelect == $past(instrWord[7]))
        else $error("Group pick wrong");
    cover property (take && instrWord[15:12] == 4'h4);
    cover property (take && instrWord[15:8] == 8'h7d);
    cover property (take && slowPeripheral);
endmodule
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the opcode decoder and state accounting
`timescale 1ns/10ps
`default_nettype none
`include "opcode_decode_map.vh"
module testbench;
    logic        clk_sys, reset_n, instrValid, dataToPeripheral, slowPeripheral;
    logic        decodeReady, groupSelect, storeDirection, resultValid;
    logic [15:0] instrWord;
    logic [3:0]  opClass;
    logic [11:0] cycleCounts;
    logic [7:0]  totalStates;
    logic [1:0]  targetSel;
    int          err_total = 0, tests_run = 0, cycleCount = 0;
    integer      seed;
    int          expQ[$];
    logic [7:0]  opList [0:19] = '{8'h40, 8'h4f, 8'h70, 8'h7d, 8'h7f, 8'h5d, 8'h5e, 8'h5f, 8'h68, 8'h69,
                                   8'h6a, 8'h6b, 8'h6c, 8'h6d, 8'h6e, 8'h6f, 8'h20, 8'h3a, 8'h00, 8'h76};
    access_target_model target_u (.targetSel(targetSel), .dataToPeripheral(dataToPeripheral),
                                  .slowPeripheral(slowPeripheral));
    opcode_decode_state_timing dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .instrWord(instrWord),
        .instrValid(instrValid), .dataToPeripheral(dataToPeripheral), .slowPeripheral(slowPeripheral),
        .decodeReady(decodeReady), .opClass(opClass), .groupSelect(groupSelect), .storeDirection(storeDirection),
        .cycleCounts(cycleCounts), .totalStates(totalStates), .resultValid(resultValid));
    // Reference cycle counts packed as {N,M,L,K,J,I}
    function automatic logic [11:0] exp_counts(input logic [15:0] w);
        logic [7:0]  f;
        logic [11:0] c;
        begin
            f = w[15:8];
            c = 12'h001;
            if (f[7:4] == 4'h4) c = 12'h002;
            if (f == 8'h7d || f == 8'h7f) c = 12'h082;
            if (f == 8'h5d) c = 12'h012;
            if (f == 8'h5e) c = 12'h812;
            if (f == 8'h5f) c = 12'h016;
            if (f[7:5] == 3'h1) c = 12'h041;
            if (f[7:3] == 5'h0d) c = {(f[2:1] == 2'h2) ? 2'h2 : 2'h0, f[0] ? 8'h40 : 8'h10, f[1] ? 2'h2 : 2'h1};
            exp_counts = c;
        end
    endfunction
    // Weighted sum of counts by per-type state cost
    function automatic int exp_total(input logic [11:0] c, input logic slow);
        exp_total = 2*c[1:0] + 2*c[3:2] + 2*c[5:4] + (slow ? 3 : 2)*c[7:6] + 2*c[9:8] + c[11:10];
    endfunction
    // Compare one result against the model
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One request, then check counts, total and result pulse together just after the edge that takes the total
    task automatic issue(input logic [15:0] w, input logic [1:0] t);
        logic [11:0] c;
        begin
            @(posedge clk_sys);
            instrWord <= w;
            targetSel <= t;
            instrValid <= 1'b1;
            c = exp_counts(w);
            expQ.push_back(exp_total(c, t[0]));
            @(posedge clk_sys);
            instrValid <= 1'b0;
            // Counts stand from the taking edge, total and result pulse from the next one
            @(posedge clk_sys);
            #1;
            chk(cycleCounts, c);
            if (w[15:12] == 4'h4) chk({8'h0, opClass}, {8'h0, `CLS_BRANCH});
            if (w[15:10] == 6'h1d) chk({11'h0, groupSelect}, {11'h0, w[7]});
            if (w[15:13] == 3'h1) chk({11'h0, storeDirection}, {11'h0, w[12]});
            if (w[15:11] == 5'h0d) chk({11'h0, storeDirection}, {11'h0, w[7]});
            chk({3'h0, resultValid, totalStates}, {4'h1, 8'(expQ.pop_front())});
        end
    endtask
    // Print the verdict and end the run
    task automatic stop_test();
        if (err_total == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Free-running system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Hang guard
    always @(posedge clk_sys)
    begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == 5000)
        begin
            err_total++;
            stop_test();
        end
    end
    // Directed codes on every target, then random words
    initial
    begin
        instrWord = 16'h0000;
        instrValid = 1'b0;
        targetSel = 2'h0;
        reset_n = 1'b0;
        seed = 19786;
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        foreach (opList[n])
            for (int t = 0; t < 4; t++)
                issue({opList[n], t[1] ? 8'h80 : 8'h05}, t[1:0]);
        // Reset in mid-run: ready, no result, class and total cleared
        @(posedge clk_sys);
        reset_n <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk({10'h0, decodeReady, resultValid}, 12'h002);
        chk({opClass, totalStates}, 12'h000);
        @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (300) issue(16'($random(seed)), 2'($random(seed)));
        stop_test();
    end
endmodule
bind opcode_decode_state_timing opcode_decode_checker chk_u (.clk_sys(clk_sys), .reset_n(reset_n),
    .instrWord(instrWord), .instrValid(instrValid), .dataToPeripheral(dataToPeripheral),
    .slowPeripheral(slowPeripheral), .decodeReady(decodeReady), .opClass(opClass), .groupSelect(groupSelect),
    .storeDirection(storeDirection), .cycleCounts(cycleCounts), .totalStates(totalStates),
    .resultValid(resultValid));
`default_nettype wire
